/* hdl/rbmc_pkg.sv */
package rbmc_pkg;

  // Strap window length and watchdog reset stretch, in system-clock cycles
  localparam int          WIN_CYC       = 10;
  localparam int          WDOG_HOLD_CYC = 10;

  // Register byte offsets
  localparam logic [7:0]  REG_CMD       = 8'h00;
  localparam logic [7:0]  REG_CFG       = 8'h04;
  localparam logic [7:0]  REG_PCLK      = 8'h08;
  localparam logic [7:0]  REG_PIOOE     = 8'h0c;
  localparam logic [7:0]  REG_STAT      = 8'h10;

  // Command register fields
  localparam int          CMD_REMAP     = 0;

  // Configuration register fields
  localparam int          CFG_L27_OE    = 0;
  localparam int          CFG_L27_OUT   = 1;
  localparam int          CFG_CKO_GPIO  = 2;
  localparam int          CFG_CKO_VAL   = 3;
  localparam int          CFG_W         = 4;

  // Status register fields
  localparam int          STAT_BOOT     = 0;
  localparam int          STAT_FLOAT    = 1;
  localparam int          STAT_REMAP    = 2;
  localparam int          STAT_SCAN     = 3;
  localparam int          STAT_WDCAUSE  = 4;
  localparam int          STAT_L27_IN   = 5;

  // Reset values
  localparam logic [3:0]  CFG_RST       = 4'h0;
  localparam logic        BOOT_RST      = 1'b1;
  localparam logic        FLOAT_RST     = 1'b0;

  // Test port instruction codes
  localparam logic [3:0]  INS_EXTEST    = 4'h0;
  localparam logic [3:0]  INS_SAMPLE    = 4'h1;
  localparam logic [3:0]  INS_BYPASS    = 4'hf;

  // Identification values are arbitrary
  localparam logic [31:0] CORE_ID_DEF   = 32'h0a5a_0001;
  localparam logic [31:0] CHIP_ID_DEF   = 32'h0a5a_1003;

  typedef enum logic [1:0] {
    RBMC_OP_BYPASS,
    RBMC_OP_SAMPLE,
    RBMC_OP_EXTEST
  } rbmc_tap_op_t;

endpackage : rbmc_pkg

/* hdl/rbmc_rst_sync.sv */
`timescale 1ns/1ps

module rbmc_rst_sync (
  // Clock and resets
  input  wire logic sys_clk_in,
  input  wire logic srst_in,
  input  wire logic arst_low_in,
  // Synchronised reset, high while held
  output logic      rst_out
);

  logic meta;
  logic hold;

  // Asserts at once, releases after two clock edges
  always_ff @(posedge sys_clk_in or negedge arst_low_in) begin
    if (!arst_low_in) begin
      meta <= 1'b1;
      hold <= 1'b1;
    end else if (srst_in) begin
      meta <= 1'b1;
      hold <= 1'b1;
    end else begin
      meta <= 1'b0;
      hold <= meta;
    end
  end

  assign rst_out = hold;

endmodule : rbmc_rst_sync

/* hdl/rbmc_top.sv */
// Added by the designer: the plain strobed port and the address map.
`timescale 1ns/1ps

// Overview of operation
// - External reset asserts at once; release follows the system clock.
// - Float strap sampled over the last ten cycles before reset rises; boot strap sampled in the last cycle only.
// - Captured boot strap chooses the boot memory type.
// - Float strap low through the window floats the peripheral pin, line 27 and clock output drivers; bus address lines stay driven.
// - Watchdog reset acts like external reset but keeps strap modes.
// - External reset wins over a simultaneous watchdog reset.
// - External reset leaves debug logic alone; only test reset clears it.
// - Reset restores register defaults and fetches from address zero.
// - External bus address lines are driven low during reset.
// - Peripheral clocks are gated off during reset.
// - Clock output carries slow clock until software reassigns the pin.
// - Peripheral-capable pins are inputs after reset.
// - Boot strap pin is ordinary general-purpose I/O after release.
// - Select low gives emulation debug, high gives boundary scan.
// - Boundary scan offers SAMPLE, EXTEST and BYPASS.
// - Emulation mode returns a core identification code instead.
// - Boot strap one selects 8-bit, zero 16-bit memory on first select.
// - Remap holds until an internal or external reset.
module rbmc_top #(
  parameter int          ADDR_W    = 24,
  parameter int          PCLK_W    = 8,
  parameter int          PIN_W     = 32,
  parameter int          WDOG_HOLD = rbmc_pkg::WDOG_HOLD_CYC,
  parameter logic [31:0] CORE_ID   = rbmc_pkg::CORE_ID_DEF,
  parameter logic [31:0] CHIP_ID   = rbmc_pkg::CHIP_ID_DEF
) (
  // Clock and reset
  input  wire logic              sys_clk_in,
  input  wire logic              srst_in,
  // Board side
  input  wire logic              external_reset_low_in,
  input  wire logic              watchdog_reset_in,
  input  wire logic              boot_select_strap_in,
  input  wire logic              output_float_strap_in,
  input  wire logic              slow_clock_in,
  // Test port
  input  wire logic              debug_port_select_in,
  input  wire logic              test_logic_reset_low_in,
  input  wire logic [3:0]        tap_instr_in,
  output logic                   tap_scan_mode_out,
  output rbmc_pkg::rbmc_tap_op_t tap_op_out,
  output logic [31:0]            tap_idcode_out,
  // Register port
  input  wire logic [7:0]        reg_addr_in,
  input  wire logic [31:0]       reg_wdata_in,
  input  wire logic              reg_wr_in,
  input  wire logic              reg_rd_in,
  output logic [31:0]            reg_rdata_out,
  // Core and memory
  output logic                   internal_reset_out,
  output logic                   cpu_fetch_zero_out,
  output logic                   boot_8bit_out,
  output logic                   remap_out,
  input  wire logic [ADDR_W-1:0] ebi_addr_in,
  output logic [ADDR_W-1:0]      ebi_addr_out,
  // Clocks and pins
  output logic [PCLK_W-1:0]      periph_clk_en_out,
  output logic [PIN_W-1:0]       periph_oe_out,
  output logic                   output_float_out,
  output logic                   port_a_line_27_out,
  output logic                   port_a_line_27_oe_out,
  output logic                   clock_output_pin_out,
  output logic                   clock_output_pin_oe_out
);

  localparam int WDW = $clog2(WDOG_HOLD + 1);
  localparam int CW  = $clog2(rbmc_pkg::WIN_CYC + 1);

  logic                   rst_sync;
  logic                   rel_pulse;
  logic                   int_rst;
  logic                   ext_prev;
  logic [WDW-1:0]         wd_cnt;
  logic                   wd_cause;
  logic [rbmc_pkg::WIN_CYC-1:0] float_hist;
  logic                   boot_last;
  logic [CW-1:0]          win_cnt;
  logic                   boot_mode;
  logic                   float_mode;
  logic                   remap;
  logic [rbmc_pkg::CFG_W-1:0] cfg;
  logic [PCLK_W-1:0]      pclk_en;
  logic [PIN_W-1:0]       pio_oe;
  logic [ADDR_W-1:0]      addr_q;
  logic                   cko_q;
  logic                   scan_mode;
  logic [31:0]            next_rdata;

  rbmc_rst_sync u_sync (
    .sys_clk_in  (sys_clk_in),
    .srst_in     (srst_in),
    .arst_low_in (external_reset_low_in),
    .rst_out     (rst_sync)
  );

  // Raw pin term gives immediate assertion
  assign int_rst = srst_in | ~external_reset_low_in | rst_sync
                 | (wd_cnt != '0);
  // Last synchroniser cycle, so modes are valid when reset drops
  assign rel_pulse = rst_sync & ext_prev & external_reset_low_in
                   & (win_cnt != '0);

  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      ext_prev   <= 1'b1;
    end else begin
      ext_prev   <= external_reset_low_in;
    end
  end

  // Watchdog reset stretch; external reset clears it
  always_ff @(posedge sys_clk_in) begin
    if (srst_in || !external_reset_low_in) begin
      wd_cnt <= '0;
    end else if (watchdog_reset_in) begin
      wd_cnt <= WDW'(WDOG_HOLD);
    end else if (wd_cnt != '0) begin
      wd_cnt <= wd_cnt - 1'b1;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (srst_in || !external_reset_low_in) begin
      wd_cause <= 1'b0;
    end else if (watchdog_reset_in) begin
      wd_cause <= 1'b1;
    end
  end

  // Strap history while the external reset pin is low
  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      float_hist <= '1;
      boot_last  <= rbmc_pkg::BOOT_RST;
      win_cnt    <= '0;
    end else if (!external_reset_low_in) begin
      float_hist <= {float_hist[rbmc_pkg::WIN_CYC-2:0],
                     output_float_strap_in};
      boot_last  <= boot_select_strap_in;
      if (ext_prev) begin
        win_cnt <= CW'(1);
      end else if (win_cnt != CW'(rbmc_pkg::WIN_CYC)) begin
        win_cnt <= win_cnt + 1'b1;
      end
    end
  end

  // Modes change only at external reset release
  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      boot_mode  <= rbmc_pkg::BOOT_RST;
      float_mode <= rbmc_pkg::FLOAT_RST;
    end else if (rel_pulse) begin
      boot_mode  <= boot_last;
      float_mode <= (win_cnt == CW'(rbmc_pkg::WIN_CYC))
                  && (float_hist == '0);
    end
  end

  assign boot_8bit_out    = boot_mode;
  assign output_float_out = float_mode;

  // Remap holds until any reset
  always_ff @(posedge sys_clk_in) begin
    if (int_rst) begin
      remap <= 1'b0;
    end else if (reg_wr_in && reg_addr_in == rbmc_pkg::REG_CMD
                 && reg_wdata_in[rbmc_pkg::CMD_REMAP]) begin
      remap <= 1'b1;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (int_rst) begin
      cfg     <= rbmc_pkg::CFG_RST;
      pclk_en <= '0;
      pio_oe  <= '0;
    end else if (reg_wr_in) begin
      unique case (reg_addr_in)
        rbmc_pkg::REG_CFG:   cfg     <= reg_wdata_in[rbmc_pkg::CFG_W-1:0];
        rbmc_pkg::REG_PCLK:  pclk_en <= reg_wdata_in[PCLK_W-1:0];
        rbmc_pkg::REG_PIOOE: pio_oe  <= reg_wdata_in[PIN_W-1:0];
        default: ;
      endcase
    end
  end

  always_comb begin
    next_rdata = '0;
    unique case (reg_addr_in)
      rbmc_pkg::REG_CFG:   next_rdata[rbmc_pkg::CFG_W-1:0] = cfg;
      rbmc_pkg::REG_PCLK:  next_rdata[PCLK_W-1:0] = pclk_en;
      rbmc_pkg::REG_PIOOE: next_rdata[PIN_W-1:0] = pio_oe;
      rbmc_pkg::REG_STAT: begin
        next_rdata[rbmc_pkg::STAT_BOOT]    = boot_mode;
        next_rdata[rbmc_pkg::STAT_FLOAT]   = float_mode;
        next_rdata[rbmc_pkg::STAT_REMAP]   = remap;
        next_rdata[rbmc_pkg::STAT_SCAN]    = scan_mode;
        next_rdata[rbmc_pkg::STAT_WDCAUSE] = wd_cause;
        next_rdata[rbmc_pkg::STAT_L27_IN]  = boot_select_strap_in;
      end
      default: ;
    endcase
  end

  // Read data stand one cycle only
  always_ff @(posedge sys_clk_in) begin
    if (srst_in || !reg_rd_in) begin
      reg_rdata_out <= '0;
    end else begin
      reg_rdata_out <= next_rdata;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    addr_q <= ebi_addr_in;
    cko_q  <= slow_clock_in;
  end

  assign internal_reset_out    = int_rst;
  assign cpu_fetch_zero_out    = int_rst;
  assign remap_out             = remap;
  assign ebi_addr_out          = int_rst ? '0 : addr_q;
  assign periph_clk_en_out     = int_rst ? '0 : pclk_en;
  assign periph_oe_out         = (int_rst | float_mode) ? '0 : pio_oe;
  assign port_a_line_27_out    = cfg[rbmc_pkg::CFG_L27_OUT];
  assign port_a_line_27_oe_out = cfg[rbmc_pkg::CFG_L27_OE] & ~int_rst
                               & ~float_mode;
  assign clock_output_pin_out  = cfg[rbmc_pkg::CFG_CKO_GPIO]
                               ? cfg[rbmc_pkg::CFG_CKO_VAL] : cko_q;
  assign clock_output_pin_oe_out = ~float_mode;

  // Test port state; external reset never touches it
  always_ff @(posedge sys_clk_in) begin
    if (srst_in || !test_logic_reset_low_in) begin
      scan_mode  <= debug_port_select_in;
      tap_op_out <= rbmc_pkg::RBMC_OP_BYPASS;
    end else if (!scan_mode) begin
      tap_op_out <= rbmc_pkg::RBMC_OP_BYPASS;
    end else begin
      case (tap_instr_in)
        rbmc_pkg::INS_EXTEST: tap_op_out <= rbmc_pkg::RBMC_OP_EXTEST;
        rbmc_pkg::INS_SAMPLE: tap_op_out <= rbmc_pkg::RBMC_OP_SAMPLE;
        default:              tap_op_out <= rbmc_pkg::RBMC_OP_BYPASS;
      endcase
    end
  end

  always_ff @(posedge sys_clk_in) begin
    tap_idcode_out <= scan_mode ? CHIP_ID : CORE_ID;
  end

  assign tap_scan_mode_out = scan_mode;

  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (srst_in);

  property p_async_assert;
    !external_reset_low_in |-> internal_reset_out;
  endproperty
  a_async_assert: assert property (p_async_assert)
    else $error("reset not asserted with pin low");

  sequence s_pin_rise;
    !external_reset_low_in ##1 external_reset_low_in;
  endsequence
  property p_sync_release;
    s_pin_rise |-> internal_reset_out ##1 internal_reset_out;
  endproperty
  a_sync_release: assert property (p_sync_release)
    else $error("reset released before synchroniser");

  property p_boot_capture;
    rel_pulse |=> boot_mode == $past(boot_last);
  endproperty
  a_boot_capture: assert property (p_boot_capture)
    else $error("boot mode not taken from last sample");

  property p_float_off;
    output_float_out |-> periph_oe_out == '0 && !port_a_line_27_oe_out
                         && !clock_output_pin_oe_out;
  endproperty
  a_float_off: assert property (p_float_off)
    else $error("driver enabled in float mode");

  property p_wd_keep;
    (wd_cnt != '0 && !rel_pulse) |=> $stable(boot_mode)
                                     && $stable(float_mode);
  endproperty
  a_wd_keep: assert property (p_wd_keep)
    else $error("watchdog reset changed strap modes");

  property p_ext_prio;
    !external_reset_low_in |=> wd_cnt == '0;
  endproperty
  a_ext_prio: assert property (p_ext_prio)
    else $error("watchdog stretch survived external reset");

  property p_tap_keep;
    test_logic_reset_low_in |=> $stable(scan_mode);
  endproperty
  a_tap_keep: assert property (p_tap_keep)
    else $error("debug mode changed without test reset");

  property p_addr_low;
    internal_reset_out |-> ebi_addr_out == '0 && periph_clk_en_out == '0;
  endproperty
  a_addr_low: assert property (p_addr_low)
    else $error("address or clock active in reset");

  sequence s_cko_slow;
    !cfg[rbmc_pkg::CFG_CKO_GPIO] ##1 !cfg[rbmc_pkg::CFG_CKO_GPIO];
  endsequence
  property p_cko;
    s_cko_slow |-> clock_output_pin_out == $past(slow_clock_in);
  endproperty
  a_cko: assert property (p_cko)
    else $error("clock output not following slow clock");

  property p_remap_hold;
    remap_out && !internal_reset_out |=> remap_out;
  endproperty
  a_remap_hold: assert property (p_remap_hold)
    else $error("remap lost without reset");

  property p_idcode;
    !tap_scan_mode_out ##1 !tap_scan_mode_out |-> tap_idcode_out == CORE_ID;
  endproperty
  a_idcode: assert property (p_idcode)
    else $error("debug mode not returning core code");

  property p_extest;
    tap_scan_mode_out && test_logic_reset_low_in
      && tap_instr_in == rbmc_pkg::INS_EXTEST
      |=> tap_op_out == rbmc_pkg::RBMC_OP_EXTEST;
  endproperty
  a_extest: assert property (p_extest)
    else $error("extest not decoded");

  property p_pins_in;
    $fell(internal_reset_out) |-> periph_oe_out == '0;
  endproperty
  a_pins_in: assert property (p_pins_in)
    else $error("pin driven right after reset");

endmodule : rbmc_top

/* verification/rbmc_board.sv */
`timescale 1ns/1ps

module rbmc_board (
  // Controls
  input  wire logic clk_in,
  input  wire logic boot_in,
  input  wire logic flt_low_in,
  // Board pins
  output logic      external_reset_low_out,
  output logic      boot_out,
  output logic      float_out,
  output logic      slow_clock_out
);
  logic [1:0] div;

  initial begin
    external_reset_low_out = 1'b0;
    slow_clock_out = 1'b0;
    div      = 2'h0;
  end

  assign boot_out  = boot_in;
  assign float_out = flt_low_in ? 1'b0 : 1'b1;

  always @(posedge clk_in) begin
    div <= div + 2'h1;
    if (div == 2'h3) slow_clock_out <= ~slow_clock_out;
  end

  task automatic hold_reset(input int n);
    int k;
    k = (n < 10) ? 10 : n;
    @(posedge clk_in);
    external_reset_low_out <= 1'b0;
    repeat (k) @(posedge clk_in);
    external_reset_low_out <= 1'b1;
  endtask : hold_reset
endmodule : rbmc_board

/* verification/testbench.sv */
`timescale 1ns/1ps

module testbench;
  localparam int WDOG = rbmc_pkg::WDOG_HOLD_CYC;
  logic        clk, srst, wdog, dsel, trst_n, boot_v, flt_low, wr, rd;
  logic        scan, irst, fetch0, b8, remap, flt_mode;
  logic        l27, l27_oe, cko, cko_oe;
  logic [3:0]  instr;
  logic [7:0]  addr, pclk_en;
  logic [23:0] ebi_in, ebi_out;
  logic [31:0] wdata, rdata, idcode, poe, seed, d, r;
  wire  logic  external_reset_low, boot_s, flt_s, slow_clock;
  rbmc_pkg::rbmc_tap_op_t op;
  int          mismatches, tests_run, cycles, k;

  rbmc_board board (.clk_in(clk), .boot_in(boot_v), .flt_low_in(flt_low),
    .external_reset_low_out(external_reset_low), .boot_out(boot_s), .float_out(flt_s), .slow_clock_out(slow_clock));

  rbmc_top #(.WDOG_HOLD(WDOG)) uut (
    .sys_clk_in(clk), .srst_in(srst), .external_reset_low_in(external_reset_low),
    .watchdog_reset_in(wdog), .boot_select_strap_in(boot_s),
    .output_float_strap_in(flt_s), .slow_clock_in(slow_clock),
    .debug_port_select_in(dsel), .test_logic_reset_low_in(trst_n),
    .tap_instr_in(instr), .tap_scan_mode_out(scan), .tap_op_out(op),
    .tap_idcode_out(idcode), .reg_addr_in(addr), .reg_wdata_in(wdata),
    .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata),
    .internal_reset_out(irst), .cpu_fetch_zero_out(fetch0),
    .boot_8bit_out(b8), .remap_out(remap), .ebi_addr_in(ebi_in),
    .ebi_addr_out(ebi_out), .periph_clk_en_out(pclk_en),
    .periph_oe_out(poe), .output_float_out(flt_mode),
    .port_a_line_27_out(l27), .port_a_line_27_oe_out(l27_oe),
    .clock_output_pin_out(cko), .clock_output_pin_oe_out(cko_oe));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic final_report();
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : final_report

  always @(posedge clk) begin
    cycles++;
    if (cycles > 6000) begin
      mismatches++;
      final_report();
    end
  end

  task automatic chk_bit(input string n, input logic e, input logic g);
    tests_run++;
    if (g !== e) begin
      mismatches++;
      $display("CHECK FAILED %s exp %b got %b", n, e, g);
    end
  endtask : chk_bit

  task automatic chk_word(input string n, input logic [31:0] e,
                          input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      mismatches++;
      $display("CHECK FAILED %s exp %h got %h", n, e, g);
    end
  endtask : chk_word

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd

  function automatic rbmc_pkg::rbmc_tap_op_t exp_op(input logic sc,
                                                     input logic [3:0] i);
    if (!sc) return rbmc_pkg::RBMC_OP_BYPASS;
    if (i == rbmc_pkg::INS_EXTEST) return rbmc_pkg::RBMC_OP_EXTEST;
    if (i == rbmc_pkg::INS_SAMPLE) return rbmc_pkg::RBMC_OP_SAMPLE;
    return rbmc_pkg::RBMC_OP_BYPASS;
  endfunction : exp_op

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    addr  <= a;
    wdata <= v;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
  endtask : wr_reg

  task automatic rd_reg(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd   <= 1'b0;
    #1 v = rdata;
  endtask : rd_reg

  // Clock pin follows the slow clock one cycle late
  task automatic cko_follow();
    logic s;
    repeat (3) begin
      @(posedge clk);
      s = slow_clock;
      #1 chk_bit("cko", s, cko);
    end
  endtask : cko_follow

  task automatic ext_reset(input int n, input logic b8e, input logic fle);
    fork
      board.hold_reset(n);
      begin
        @(posedge clk);
        #1 chk_bit("irst", 1'b1, irst);
        cko_follow();
        chk_word("ebi", 32'h0, {8'h0, ebi_out});
        chk_word("pclk", 32'h0, {24'h0, pclk_en});
        chk_bit("fetch0", 1'b1, fetch0);
      end
    join
    @(posedge clk);
    #1 chk_bit("irst", 1'b1, irst);
    @(posedge clk);
    #1 chk_bit("irst", 1'b0, irst);
    chk_bit("boot8", b8e, b8);
    chk_bit("float", fle, flt_mode);
    chk_bit("remap", 1'b0, remap);
  endtask : ext_reset

  task automatic tap_reset();
    @(posedge clk);
    trst_n <= 1'b0;
    @(posedge clk);
    trst_n <= 1'b1;
    repeat (2) @(posedge clk);
    #1;
  endtask : tap_reset

  task automatic tap_sweep(input logic sc);
    for (int i = 0; i < 16; i++) begin
      @(posedge clk);
      instr <= 4'(i);
      @(posedge clk);
      #1 chk_word("op", 32'(exp_op(sc, 4'(i))), 32'(op));
    end
  endtask : tap_sweep

  initial begin
    seed = 32'd81;
    {srst, wdog, dsel, wr, rd, flt_low} = 6'b100000;
    {trst_n, boot_v} = 2'b11;
    instr = 4'h0;
    addr = 8'h0;
    wdata = 32'h0;
    ebi_in = 24'h0;
    repeat (20) @(posedge clk);
    srst <= 1'b0;
    board.hold_reset(10);
    k = 0;
    while (irst !== 1'b0 && k < 20) begin
      @(posedge clk);
      #1 k++;
    end
    rd_reg(rbmc_pkg::REG_STAT, d);
    chk_word("stat", 32'h21, d);
    @(posedge clk);
    #1 chk_word("rdidle", 32'h0, rdata);
    for (int j = 0; j < 8; j++) begin
      rd_reg(8'(j * 4), d);
      if (j != 4) chk_word("regrst", 32'h0, d);
    end
    chk_word("poe", 32'h0, poe);
    chk_bit("l27oe", 1'b0, l27_oe);
    for (int i = 0; i < 16; i++) begin
      d = rnd();
      wr_reg(rbmc_pkg::REG_PCLK, d);
      ebi_in <= d[31:8] | 24'h1;
      wr_reg(rbmc_pkg::REG_PIOOE, ~d);
      #1 chk_word("pclk", {24'h0, d[7:0]}, {24'h0, pclk_en});
      chk_word("poe", ~d, poe);
      chk_word("ebi", {8'h0, d[31:8] | 24'h1}, {8'h0, ebi_out});
      rd_reg(rbmc_pkg::REG_PCLK, r);
      chk_word("pclkrd", {24'h0, d[7:0]}, r);
    end
    wr_reg(rbmc_pkg::REG_CMD, 32'h1);
    #1 chk_bit("remap", 1'b1, remap);
    @(posedge clk);
    boot_v <= 1'b0;
    ext_reset(12, 1'b0, 1'b0);
    rd_reg(rbmc_pkg::REG_PCLK, d);
    chk_word("pclkrd", 32'h0, d);
    @(posedge clk);
    flt_low <= 1'b1;
    boot_v <= 1'b1;
    ext_reset(10, 1'b1, 1'b1);
    wr_reg(rbmc_pkg::REG_PIOOE, 32'hffff_ffff);
    wr_reg(rbmc_pkg::REG_CFG, 32'h1);
    #1 chk_word("poe", 32'h0, poe);
    chk_bit("l27oe", 1'b0, l27_oe);
    chk_bit("ckooe", 1'b0, cko_oe);
    wr_reg(rbmc_pkg::REG_CMD, 32'h1);
    @(posedge clk);
    {flt_low, boot_v, wdog} <= 3'b001;
    @(posedge clk);
    wdog <= 1'b0;
    #1 k = (irst === 1'b1) ? 1 : 0;
    repeat (30) begin
      @(posedge clk);
      #1 if (irst === 1'b1) k++;
    end
    chk_word("wdlen", 32'(WDOG), 32'(k));
    chk_bit("boot8", 1'b1, b8);
    chk_bit("float", 1'b1, flt_mode);
    chk_bit("remap", 1'b0, remap);
    rd_reg(rbmc_pkg::REG_STAT, d);
    chk_word("stat", 32'h13, d);
    @(posedge clk);
    {flt_low, boot_v} <= 2'b10;
    fork
      ext_reset(12, 1'b0, 1'b0);
      begin
        repeat (3) @(posedge clk);
        wdog <= 1'b1;
        @(posedge clk);
        wdog <= 1'b0;
        repeat (6) @(posedge clk);
        flt_low <= 1'b0;
      end
    join
    rd_reg(rbmc_pkg::REG_STAT, d);
    chk_word("stat", 32'h0, d);
    wr_reg(rbmc_pkg::REG_CFG, 32'h3);
    #1 chk_word("l27", 32'h3, {30'h0, l27, l27_oe});
    @(posedge clk);
    boot_v <= 1'b1;
    rd_reg(rbmc_pkg::REG_STAT, d);
    chk_word("stat", 32'h20, d);
    cko_follow();
    chk_bit("ckooe", 1'b1, cko_oe);
    wr_reg(rbmc_pkg::REG_CFG, 32'hc);
    @(posedge clk);
    #1 chk_bit("cko", 1'b1, cko);
    wr_reg(rbmc_pkg::REG_CFG, 32'h4);
    @(posedge clk);
    #1 chk_bit("cko", 1'b0, cko);
    tap_reset();
    chk_word("id", rbmc_pkg::CORE_ID_DEF, idcode);
    tap_sweep(1'b0);
    @(posedge clk);
    dsel <= 1'b1;
    ext_reset(10, 1'b1, 1'b0);
    tap_reset();
    chk_bit("scan", 1'b1, scan);
    chk_word("id", rbmc_pkg::CHIP_ID_DEF, idcode);
    tap_sweep(1'b1);
    @(posedge clk);
    dsel <= 1'b0;
    ext_reset(10, 1'b1, 1'b0);
    chk_bit("scan", 1'b1, scan);
    final_report();
  end
endmodule : testbench
